// ===== rtl/serial_port_pkg.sv
// constants for the byte-wide asynchronous serial port: offsets, fields, resets, rates
// assumes a 16-bit register port and one system clock feeding all logic
// Functional notes
// - the enable bit runs the port when 1, and when 0 stops it and hands both pins back to gpio
// - every bit rate is derived from the system clock so the average rate is exact
// - the prescale bit at 1 divides the selected rate by eight, at 0 the plain rate applies
// - without prescale codes 0..7 give 115.2 57.6 38.4 28.8 19.2 14.4 9.6 7.2 kilobaud
// - with prescale codes 0..7 give 14.4 7.2 4.8 3.6 2.4 1.8 1.2 0.9 kilobaud
// - flags bit 1 shows a waiting received byte and clears when the data register is read
// - a full receive buffer raises processor interrupt 5 while the serial enable is set
// - flags bit 0 goes to 1 as soon as a byte is written for sending
// - flags bit 0 returns to 0 once that byte has been fully shifted out
// - an empty transmit buffer raises processor interrupt 4 while the enable bit and the serial enable are both set
// - a write to the data register while flags bit 0 is 0 loads the byte and starts sending it on the transmit pin; the code also needs the enable bit at 1
// - the data register carries the byte in bits 7..0 and its upper bits read as zero
// - the flags register is read only and writes never change its flags
package serial_port_pkg;
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int RATE_UNIT_HZ = 100;
   localparam int OVERSAMPLE = 16;
   localparam int PRESCALE_FACTOR = 8;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] BIT_LAST_TICK = 4'hF;
   localparam logic [2:0] LAST_DATA_BIT = 3'h7;
   localparam logic [15:0] CTRL_OFF = 16'hC0E0;
   localparam logic [15:0] FLAGS_OFF = 16'hC0E2;
   localparam logic [15:0] BYTE_OFF = 16'hC0E4;
   localparam logic [15:0] EVT_STAT_OFF = 16'hC100;
   localparam logic [15:0] EVT_MASK_OFF = 16'hC102;
   localparam logic [15:0] CTRL_RESET = 16'h0007;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_BAUD_LSB = 1;
   localparam int CTRL_BAUD_MSB = 3;
   localparam int CTRL_DIVIDE_BY_EIGHT_PRESCALE_BIT = 4;
   localparam int FLAG_TX_FULL_BIT = 0;
   localparam int FLAG_RX_FULL_BIT = 1;
   localparam int EVT_W = 4;
   localparam int EVT_RX_DONE = 0;
   localparam int EVT_TX_DONE = 1;
   localparam int EVT_OVERRUN = 2;
   localparam int EVT_FRAME = 3;
   localparam logic [EVT_W-1:0] EVT_MASK_RESET = 4'h0;
   // rates in units of RATE_UNIT_HZ, indexed by the baud code
   localparam logic [10:0] BAUD_UNITS [0:7] = '{11'd1152, 11'd576, 11'd384, 11'd288,
                                                 11'd192, 11'd144, 11'd96, 11'd72};
endpackage : serial_port_pkg

// ===== rtl/baud_nco.sv
// fractional rate generator giving one oversample tick per sixteenth of a bit
// assumes the clock rate is a multiple of RATE_UNIT_HZ
`timescale 1ns/10ps
module baud_nco #(
   parameter int CLK_HZ = serial_port_pkg::SYS_CLK_HZ
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [2:0] baud_sel,
   input wire logic divide_by_eight_prescale,
   output logic tick
);
   import serial_port_pkg::*;
   localparam logic [20:0] MODULUS = 21'(CLK_HZ / RATE_UNIT_HZ);
   localparam int FULL_STEP = OVERSAMPLE;
   localparam int SLOW_STEP = OVERSAMPLE / PRESCALE_FACTOR;
   logic [20:0] acc_reg;
   logic [20:0] acc_next;
   logic [20:0] inc;
   logic [20:0] sum;
   always_comb
   begin
      if (divide_by_eight_prescale)
         inc = 21'(BAUD_UNITS[baud_sel]) * 21'(SLOW_STEP);
      else
         inc = 21'(BAUD_UNITS[baud_sel]) * 21'(FULL_STEP);
      sum = acc_reg + inc;
      if (sum >= MODULUS)
         acc_next = sum - MODULUS;
      else
         acc_next = sum;
   end
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         acc_reg <= 21'h000000;
      else if (!run)
         acc_reg <= 21'h000000;
      else
         acc_reg <= acc_next;
   end
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         tick <= 1'b0;
      else
         tick <= run && (sum >= MODULUS);
   end
endmodule : baud_nco

// ===== rtl/embedded_uart_port.sv
// serial port top: register port, transmitter, receiver, pin hand-over, interrupts
// assumes one clock, the gpio block supplies pin 28 drive when the port is off
`timescale 1ns/10ps
module embedded_uart_port #(
   parameter int CLK_HZ = serial_port_pkg::SYS_CLK_HZ
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic sys_uart_irq_en,
   output logic irq_tx_empty,
   output logic irq_rx_full,
   output logic irq_event,
   input wire logic gpio_28_out_alt,
   input wire logic gpio_28_oe_alt,
   output logic general_io_pin_28_out,
   output logic general_io_pin_28_oe,
   input wire logic general_io_pin_27_in,
   output logic port_owns_pins
);
   import serial_port_pkg::*;

   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_START = 4'b0010,
      TX_DATA = 4'b0100,
      TX_STOP = 4'b1000
   } tx_state_e;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_e;

   logic ctrl_en_reg, divide_by_eight_prescale_reg, tick, rx_meta_reg, rx_sync_reg;
   logic [2:0] baud_sel_reg;
   tx_state_e tx_state_reg;
   rx_state_e rx_state_reg;
   logic [3:0] tx_tick_reg, rx_tick_reg;
   logic [2:0] tx_bit_reg, rx_bit_reg;
   logic [7:0] tx_shift_reg, rx_shift_reg, rx_byte_reg;
   logic tx_line_reg, tx_full_reg, tx_done, rx_full_reg, rx_done, rx_frame_err;
   logic [EVT_W-1:0] evt_stat_reg, evt_mask_reg, evt_set;
   logic [15:0] rd_mux;
   logic ctrl_wr, byte_wr, byte_rd, stat_wr, mask_wr, tx_load, tx_bit_end, rx_bit_end;

   assign ctrl_wr = reg_wr && (reg_addr == CTRL_OFF);
   assign byte_wr = reg_wr && (reg_addr == BYTE_OFF);
   assign byte_rd = reg_rd && (reg_addr == BYTE_OFF);
   assign stat_wr = reg_wr && (reg_addr == EVT_STAT_OFF);
   assign mask_wr = reg_wr && (reg_addr == EVT_MASK_OFF);
   assign tx_load = byte_wr && ctrl_en_reg && !tx_full_reg;
   assign tx_bit_end = tick && (tx_tick_reg == BIT_LAST_TICK);
   assign rx_bit_end = tick && (rx_tick_reg == BIT_LAST_TICK);

   // control register, only defined fields are kept
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_en_reg <= CTRL_RESET[CTRL_EN_BIT];
         baud_sel_reg <= CTRL_RESET[CTRL_BAUD_MSB:CTRL_BAUD_LSB];
         divide_by_eight_prescale_reg <= CTRL_RESET[CTRL_DIVIDE_BY_EIGHT_PRESCALE_BIT];
      end
      else if (ctrl_wr)
      begin
         ctrl_en_reg <= reg_wdata[CTRL_EN_BIT];
         baud_sel_reg <= reg_wdata[CTRL_BAUD_MSB:CTRL_BAUD_LSB];
         divide_by_eight_prescale_reg <= reg_wdata[CTRL_DIVIDE_BY_EIGHT_PRESCALE_BIT];
      end
   end

   baud_nco #(
      .CLK_HZ(CLK_HZ)
   ) u_nco (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .run(ctrl_en_reg),
      .baud_sel(baud_sel_reg),
      .divide_by_eight_prescale(divide_by_eight_prescale_reg),
      .tick(tick)
   );

   // receive pin synchroniser
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end
      else
      begin
         rx_meta_reg <= general_io_pin_27_in;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // transmitter
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_state_reg <= TX_IDLE;
         tx_tick_reg <= 4'h0;
         tx_bit_reg <= 3'h0;
         tx_shift_reg <= 8'h00;
         tx_line_reg <= 1'b1;
      end
      else if (!ctrl_en_reg)
      begin
         tx_state_reg <= TX_IDLE;
         tx_tick_reg <= 4'h0;
         tx_bit_reg <= 3'h0;
         tx_line_reg <= 1'b1;
      end
      else
      begin
         if (tick)
            tx_tick_reg <= tx_tick_reg + 4'h1;
         unique case (tx_state_reg)
            TX_IDLE:
            begin
               if (tx_load)
               begin
                  tx_shift_reg <= reg_wdata[7:0];
                  tx_tick_reg <= 4'h0;
                  tx_bit_reg <= 3'h0;
                  tx_line_reg <= 1'b0;
                  tx_state_reg <= TX_START;
               end
            end
            TX_START:
            begin
               if (tx_bit_end)
               begin
                  tx_line_reg <= tx_shift_reg[0];
                  tx_state_reg <= TX_DATA;
               end
            end
            TX_DATA:
            begin
               if (tx_bit_end)
               begin
                  tx_bit_reg <= tx_bit_reg + 3'h1;
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  if (tx_bit_reg == LAST_DATA_BIT)
                  begin
                     tx_line_reg <= 1'b1;
                     tx_state_reg <= TX_STOP;
                  end
                  else
                     tx_line_reg <= tx_shift_reg[1];
               end
            end
            TX_STOP:
            begin
               if (tx_bit_end)
                  tx_state_reg <= TX_IDLE;
            end
         endcase
      end
   end

   assign tx_done = ctrl_en_reg && (tx_state_reg == TX_STOP) && tx_bit_end;

   // transmit-full flag
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         tx_full_reg <= 1'b0;
      else if (tx_load)
         tx_full_reg <= 1'b1;
      else if (tx_done || !ctrl_en_reg)
         tx_full_reg <= 1'b0;
   end

   // receiver
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_state_reg <= RX_IDLE;
         rx_tick_reg <= 4'h0;
         rx_bit_reg <= 3'h0;
         rx_shift_reg <= 8'h00;
      end
      else if (!ctrl_en_reg)
      begin
         rx_state_reg <= RX_IDLE;
         rx_tick_reg <= 4'h0;
         rx_bit_reg <= 3'h0;
      end
      else
      begin
         unique case (rx_state_reg)
            RX_IDLE:
            begin
               if (tick && !rx_sync_reg)
               begin
                  rx_tick_reg <= 4'h0;
                  rx_bit_reg <= 3'h0;
                  rx_state_reg <= RX_START;
               end
            end
            RX_START:
            begin
               if (tick)
               begin
                  rx_tick_reg <= rx_tick_reg + 4'h1;
                  if (rx_tick_reg == SAMPLE_MID)
                  begin
                     rx_tick_reg <= 4'h0;
                     if (rx_sync_reg)
                        rx_state_reg <= RX_IDLE;
                     else
                        rx_state_reg <= RX_DATA;
                  end
               end
            end
            RX_DATA:
            begin
               if (tick)
                  rx_tick_reg <= rx_tick_reg + 4'h1;
               if (rx_bit_end)
               begin
                  rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
                  rx_bit_reg <= rx_bit_reg + 3'h1;
                  if (rx_bit_reg == LAST_DATA_BIT)
                     rx_state_reg <= RX_STOP;
               end
            end
            RX_STOP:
            begin
               if (tick)
                  rx_tick_reg <= rx_tick_reg + 4'h1;
               if (rx_bit_end)
                  rx_state_reg <= RX_IDLE;
            end
         endcase
      end
   end

   assign rx_done = ctrl_en_reg && (rx_state_reg == RX_STOP) && rx_bit_end && rx_sync_reg;
   assign rx_frame_err = ctrl_en_reg && (rx_state_reg == RX_STOP) && rx_bit_end && !rx_sync_reg;

   // received byte holder and receive-full flag, a new byte wins over a read
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_byte_reg <= 8'h00;
         rx_full_reg <= 1'b0;
      end
      else if (rx_done)
      begin
         rx_byte_reg <= rx_shift_reg;
         rx_full_reg <= 1'b1;
      end
      else if (byte_rd)
         rx_full_reg <= 1'b0;
   end

   // sticky events, write one to clear, a new event wins over the clear
   always_comb
   begin
      evt_set = '0;
      evt_set[EVT_RX_DONE] = rx_done;
      evt_set[EVT_TX_DONE] = tx_done;
      evt_set[EVT_OVERRUN] = rx_done && rx_full_reg && !byte_rd;
      evt_set[EVT_FRAME] = rx_frame_err;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         evt_stat_reg <= '0;
      else if (stat_wr)
         evt_stat_reg <= (evt_stat_reg & ~reg_wdata[EVT_W-1:0]) | evt_set;
      else
         evt_stat_reg <= evt_stat_reg | evt_set;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         evt_mask_reg <= EVT_MASK_RESET;
      else if (mask_wr)
         evt_mask_reg <= reg_wdata[EVT_W-1:0];
   end

   // read path, writes to the flags offset decode to nothing
   always_comb
   begin
      rd_mux = 16'h0000;
      unique case (reg_addr)
         CTRL_OFF:
         begin
            rd_mux[CTRL_EN_BIT] = ctrl_en_reg;
            rd_mux[CTRL_BAUD_MSB:CTRL_BAUD_LSB] = baud_sel_reg;
            rd_mux[CTRL_DIVIDE_BY_EIGHT_PRESCALE_BIT] = divide_by_eight_prescale_reg;
         end
         FLAGS_OFF:
         begin
            rd_mux[FLAG_TX_FULL_BIT] = tx_full_reg;
            rd_mux[FLAG_RX_FULL_BIT] = rx_full_reg;
         end
         BYTE_OFF:
            rd_mux[7:0] = rx_byte_reg;
         EVT_STAT_OFF:
            rd_mux[EVT_W-1:0] = evt_stat_reg;
         EVT_MASK_OFF:
            rd_mux[EVT_W-1:0] = evt_mask_reg;
         default:
            rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
         reg_rdata <= rd_mux;
      else
         reg_rdata <= 16'h0000;
   end

   // interrupts and pin hand-over
   assign irq_rx_full = rx_full_reg && sys_uart_irq_en;
   assign irq_tx_empty = ctrl_en_reg && !tx_full_reg && sys_uart_irq_en;
   assign irq_event = |(evt_stat_reg & evt_mask_reg);
   assign general_io_pin_28_out = ctrl_en_reg ? tx_line_reg : gpio_28_out_alt;
   assign general_io_pin_28_oe = ctrl_en_reg ? 1'b1 : gpio_28_oe_alt;
   assign port_owns_pins = ctrl_en_reg;
endmodule : embedded_uart_port

// ===== tb/embedded_uart_port_sva.sv
// checker for the serial port: pin hand-over, interrupt gating, read data, transmit start
// assumes it is bound to embedded_uart_port and sees only its ports
`timescale 1ns/10ps
module embedded_uart_port_sva
   import serial_port_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic sys_uart_irq_en,
   input wire logic irq_tx_empty,
   input wire logic irq_rx_full,
   input wire logic gpio_28_out_alt,
   input wire logic gpio_28_oe_alt,
   input wire logic general_io_pin_28_out,
   input wire logic general_io_pin_28_oe,
   input wire logic general_io_pin_27_in,
   input wire logic port_owns_pins
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   AST_PIN_HANDBACK: assert property (
      !port_owns_pins |-> general_io_pin_28_out == gpio_28_out_alt
         && general_io_pin_28_oe == gpio_28_oe_alt)
      else $error("pin not handed back");
   AST_PIN_OWNED: assert property (
      port_owns_pins |-> general_io_pin_28_oe && (!irq_tx_empty || general_io_pin_28_out))
      else $error("pin not driven high while enabled and idle");
   AST_RX_IRQ_GATE: assert property (
      irq_rx_full |-> sys_uart_irq_en)
      else $error("receive interrupt without enable");
   AST_TX_IRQ_GATE: assert property (
      irq_tx_empty |-> sys_uart_irq_en && port_owns_pins)
      else $error("transmit interrupt without enable");
   AST_RDATA_IDLE: assert property (
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data without read");
   AST_BYTE_UPPER: assert property (
      reg_rd && reg_addr == BYTE_OFF |=> reg_rdata[15:8] == 8'h00)
      else $error("data upper bits not zero");
   AST_TX_START: assert property (
      reg_wr && reg_addr == BYTE_OFF && irq_tx_empty
         |=> (!irq_tx_empty && !general_io_pin_28_out) [*8])
      else $error("write did not start a character");
   AST_FLAGS_RO: assert property (
      reg_wr && reg_addr == FLAGS_OFF && irq_tx_empty |=> irq_tx_empty)
      else $error("flags write changed transmit flag");
   AST_RX_CLEAR: assert property (
      reg_rd && reg_addr == BYTE_OFF && general_io_pin_27_in && sys_uart_irq_en
         |=> !irq_rx_full)
      else $error("receive flag kept after data read");
endmodule : embedded_uart_port_sva

bind embedded_uart_port embedded_uart_port_sva u_embedded_uart_port_sva (
   .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_uart_irq_en(sys_uart_irq_en),
   .irq_tx_empty(irq_tx_empty), .irq_rx_full(irq_rx_full),
   .gpio_28_out_alt(gpio_28_out_alt), .gpio_28_oe_alt(gpio_28_oe_alt),
   .general_io_pin_28_out(general_io_pin_28_out),
   .general_io_pin_28_oe(general_io_pin_28_oe),
   .general_io_pin_27_in(general_io_pin_27_in), .port_owns_pins(port_owns_pins));

// ===== tb/serial_peer.sv
// remote serial peer: sends characters on request and captures received ones
// assumes a fixed bit time counted in system clocks
`timescale 1ns/10ps
module serial_peer #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk_sys,
   input wire logic listen,
   input wire logic line_in,
   output logic line_out,
   output logic [7:0] got_byte,
   output logic got_valid
);
   initial
   begin
      line_out = 1'b1;
      got_valid = 1'b0;
   end

   task automatic send_char(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk_sys);
         line_out <= f[i];
         repeat (BIT_CLKS - 1) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      line_out <= 1'b1;
   endtask : send_char

   always
   begin
      @(negedge line_in iff listen);
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CLKS) @(posedge clk_sys);
         got_byte[i] <= line_in;
      end
      repeat (BIT_CLKS) @(posedge clk_sys);
      got_valid <= line_in;
      @(posedge clk_sys);
      got_valid <= 1'b0;
   end
endmodule : serial_peer

// ===== tb/testbench.sv
// self-checking bench: registers, rates, both directions, events, pin hand-over
// assumes CLK_HZ is set so that code 000 gives one oversample tick per clock
`timescale 1ns/10ps
module testbench;
   import serial_port_pkg::*;
   localparam int CLK = 1843200;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0, listen = 1'b0;
   logic sys_uart_irq_en = 1'b1, gpio_28_out_alt = 1'b0, gpio_28_oe_alt = 1'b0;
   logic [15:0] reg_rdata;
   logic irq_tx_empty, irq_rx_full, irq_event, pin_out, pin_oe, pin_in, port_owns_pins;
   logic [7:0] got_byte;
   logic got_valid;
   int mismatches = 0;
   int tests_run = 0;
   int seed = 37301;
   int rate [8] = '{1152, 576, 384, 288, 192, 144, 96, 72};
   logic [15:0] rd_q [$];
   logic [7:0] tx_q [$];

   always #5 clk_sys = ~clk_sys;

   embedded_uart_port #(.CLK_HZ(CLK)) u_embedded_uart_port (
      .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sys_uart_irq_en(sys_uart_irq_en), .irq_tx_empty(irq_tx_empty),
      .irq_rx_full(irq_rx_full), .irq_event(irq_event),
      .gpio_28_out_alt(gpio_28_out_alt), .gpio_28_oe_alt(gpio_28_oe_alt),
      .general_io_pin_28_out(pin_out), .general_io_pin_28_oe(pin_oe),
      .general_io_pin_27_in(pin_in), .port_owns_pins(port_owns_pins));

   serial_peer #(.BIT_CLKS(16)) u_serial_peer (
      .clk_sys(clk_sys), .listen(listen), .line_in(pin_out), .line_out(pin_in),
      .got_byte(got_byte), .got_valid(got_valid));

   task automatic check_val(input logic [15:0] exp, input logic [15:0] act);
      tests_run++;
      if (act !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, act, exp);
      end
   endtask : check_val

   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [15:0] a, input logic [15:0] e);
      rd_q.push_back(e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : reg_read

   task automatic wait_for(input int sel);
      int n;
      n = 0;
      while (((sel == 0) ? irq_rx_full : irq_tx_empty) !== 1'b1 && n < 4000)
      begin
         @(posedge clk_sys);
         n++;
      end
      check_val(16'h0001, {15'h0, n < 4000});
   endtask : wait_for

   always @(posedge clk_sys)
      {gpio_28_out_alt, gpio_28_oe_alt} <= 2'($random(seed));

   always @(posedge clk_sys)
      rd_seen <= reg_rd;

   always @(negedge clk_sys)
      if (rd_seen === 1'b1)
         check_val(rd_q.pop_front(), reg_rdata);

   always @(posedge clk_sys)
      if (got_valid === 1'b1)
         check_val(tx_q.size() ? {8'h00, tx_q.pop_front()} : 16'hFFFF, {8'h00, got_byte});

   initial
   begin
      #500_000;
      mismatches++;
      give_verdict();
   end

   initial
   begin
      logic [7:0] b;
      int n, lim;
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      reg_read(CTRL_OFF, CTRL_RESET);
      reg_read(FLAGS_OFF, 16'h0000);
      reg_read(16'hC0E6, 16'h0000);
      check_val(16'h0001, {15'h0, irq_tx_empty});
      for (int c = 0; c < 16; c++)
      begin
         reg_write(CTRL_OFF, 16'(c * 2 + 1));
         reg_write(BYTE_OFF, 16'h0001);
         #1;
         n = 0;
         while (pin_out === 1'b0 && n < 3000)
         begin
            @(posedge clk_sys);
            n++;
         end
         lim = CLK * ((c > 7) ? 8 : 1) / (rate[c % 8] * 100);
         check_val(16'h0001, {15'h0, n >= lim - lim / 16 - 1 && n <= lim + lim / 16 + 1});
         reg_write(CTRL_OFF, 16'h0000);
         #1 check_val(16'h0000, {15'h0, port_owns_pins});
      end
      reg_write(CTRL_OFF, 16'h001F);
      reg_read(CTRL_OFF, 16'h001F);
      reg_write(CTRL_OFF, 16'h0001);
      listen <= 1'b1;
      b = 8'($random(seed));
      tx_q.push_back(b);
      reg_write(BYTE_OFF, {8'h00, b});
      reg_write(BYTE_OFF, 16'h00A5);
      reg_read(FLAGS_OFF, 16'h0001);
      wait_for(1);
      reg_read(FLAGS_OFF, 16'h0000);
      check_val(16'h0000, 16'(tx_q.size()));
      reg_read(EVT_STAT_OFF, 16'h0002);
      listen <= 1'b0;
      reg_write(EVT_STAT_OFF, 16'h000F);
      b = 8'($random(seed));
      u_serial_peer.send_char(b, 1'b1);
      wait_for(0);
      reg_read(FLAGS_OFF, 16'h0002);
      reg_write(FLAGS_OFF, 16'h0000);
      reg_read(FLAGS_OFF, 16'h0002);
      reg_read(EVT_STAT_OFF, 16'h0001);
      #1 check_val(16'h0000, {15'h0, irq_event});
      reg_write(EVT_MASK_OFF, 16'h0001);
      #1 check_val(16'h0001, {15'h0, irq_event});
      reg_write(EVT_STAT_OFF, 16'h0001);
      #1 check_val(16'h0000, {15'h0, irq_event});
      reg_read(BYTE_OFF, {8'h00, b});
      reg_read(FLAGS_OFF, 16'h0000);
      u_serial_peer.send_char(8'h3C, 1'b1);
      b = 8'($random(seed));
      u_serial_peer.send_char(b, 1'b1);
      @(posedge clk_sys);
      sys_uart_irq_en <= 1'b0;
      @(posedge clk_sys);
      #1 check_val(16'h0000, {15'h0, irq_rx_full});
      sys_uart_irq_en <= 1'b1;
      reg_read(EVT_STAT_OFF, 16'h0005);
      reg_read(BYTE_OFF, {8'h00, b});
      reg_write(EVT_STAT_OFF, 16'h000F);
      u_serial_peer.send_char(8'h55, 1'b0);
      repeat (40) @(posedge clk_sys);
      reg_read(FLAGS_OFF, 16'h0000);
      reg_read(EVT_STAT_OFF, 16'h0008);
      repeat (4) @(posedge clk_sys);
      give_verdict();
   end
endmodule : testbench
